// File: hw/sgp_pma_datapath.sv
// serializer / deserializer datapath with loopback, signal detect and
// comma word alignment
// assumes the 125 MHz reference arrives on its own clock port and that all
// other pins are asynchronous to the 200 MHz system clock
`timescale 1ns/10ps
// Contract
// R01: capture the 10-bit transmit word on every reference clock rising edge
// R02: serialize each word at line rate, bit 0 first, ascending order
// R03: serial bit clock derived from reference, exactly ten bits per period
// R04: host keeps reference frequency within 100 ppm of nominal
// R05: loopback high routes own transmit stream into the receive path
// R06: during loopback the line output holds logic one, p high, n low
// R07: weak input drops signal present and forces receive word to ones (code forces ones only with loopback low)
// R08: recover data and two 62.5 MHz receive byte clocks
// R09: transmit latency typically 4.4 bit times from capture edge
// R10: receive latency typically 28 bit times to presenting byte clock
// R11: regain bit synchronisation within 2500 bits after a phase jump
// R12: achieve frequency lock within 500 microseconds of power-up
// R13: align to comma only when enabled, otherwise comma seen stays low
// R14: words alternate on antiphase byte clocks, clock A rises on comma
// R15: first received serial bit lands in bit 0 of the receive word
// R16: host supplies already 8b/10b coded words, sent unchanged
module sgp_pma_datapath #(
	parameter int LOCK_CYCLES_P = sgp_pkg::LOCK_CYCLES
) (
	// system
	input  wire logic        mclk,
	input  wire logic        reset,
	// parallel transmit side
	input  wire logic        referenceClockIn,
	input  wire logic [9:0]  txWord,
	// control pins
	input  wire logic        loopbackEnable,
	input  wire logic        commaAlignEnable,
	// serial line
	input  wire logic        serialIn,
	input  wire logic        lineAboveThreshold,
	output sgp_pkg::sgp_diff_s serialOut,
	// parallel receive side
	output sgp_pkg::sgp_rx_s rxOut,
	output logic             rxByteClockA,
	output logic             rxByteClockB,
	output logic             signalPresent,
	output logic             freqLocked
);
	import sgp_pkg::*;

	localparam int ACC_W = PER_W + 1;
	localparam logic [ACC_W-1:0] STEP = ACC_W'(BITS_PER_WORD);
	localparam int LT_W = $clog2(LOCK_CYCLES_P + 1);

	// reference clock domain
	logic [1:0] refRstPipe;
	logic       refRst;
	logic [9:0] holdWord;
	logic       holdToggle;

	always_ff @(posedge referenceClockIn or posedge reset) begin
		if (reset) begin
			refRstPipe <= 2'h0;
		end else begin
			refRstPipe <= {refRstPipe[0], 1'b1};
		end
	end
	assign refRst = ~refRstPipe[1];

	// words go out unchanged; coding is the host's business [R16]
	always_ff @(posedge referenceClockIn or posedge refRst) begin
		if (refRst) begin
			holdWord   <= TX_RESET_WORD;
			holdToggle <= 1'b0;
		end else begin
			holdWord   <= txWord; // [R01]
			holdToggle <= ~holdToggle;
		end
	end

	// crossing: holdWord is stable for a whole reference period, far longer
	// than the toggle takes to pass its synchroniser
	logic [3:0] pinSync;
	logic       togSync;
	logic       togSeen;
	logic       newWord;
	logic       lbk;
	logic       commaEn;
	logic       sigOk;
	logic       serIn;

	sgp_sync2 #(.W(4)) pinSyncInst (
		.clk   (mclk),
		.reset (reset),
		.d     ({loopbackEnable, commaAlignEnable, lineAboveThreshold,
		         serialIn}),
		.q     (pinSync)
	);

	sgp_sync2 #(.W(1)) togSyncInst (
		.clk   (mclk),
		.reset (reset),
		.d     (holdToggle),
		.q     (togSync)
	);

	assign lbk     = pinSync[3];
	assign commaEn = pinSync[2];
	assign sigOk   = pinSync[1];
	assign serIn   = pinSync[0];
	assign newWord = togSync ^ togSeen;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			togSeen <= 1'b0;
		end else begin
			togSeen <= togSync;
		end
	end

	// reference period measured in system clocks
	logic [PER_W-1:0] perCount;
	logic [PER_W-1:0] refPeriod;
	logic [PER_W-1:0] perDiff;
	logic [ACC_W-1:0] refExt;

	assign perDiff = perCount - refPeriod;
	assign refExt  = {1'b0, refPeriod};

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			perCount   <= PER_RESET;
			refPeriod  <= PER_RESET;
			freqLocked <= 1'b0;
		end else if (newWord) begin
			perCount  <= PER_W'(1);
			refPeriod <= perCount;
			// a slip of one system clock is within the reference tolerance
			freqLocked <= (refPeriod != PER_RESET) &&
			              (perDiff == PER_W'(0) || perDiff == PER_W'(1) ||
			               perDiff == '1); // [R12] [R04]
		end else if (perCount != '1) begin
			perCount <= perCount + PER_W'(1);
		end
	end

	// transmit bit strobes: bit 0 goes out on newWord, then a fractional accumulator spreads
	// the nine strobes for bits 1 to 9 over each measured reference period
	logic [ACC_W-1:0] txAcc;
	logic [ACC_W-1:0] txAccSum;
	logic             txStrobe;

	assign txAccSum = txAcc + STEP;
	assign txStrobe = !newWord && refPeriod != PER_RESET &&
	                  txAccSum >= refExt;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			txAcc <= '0;
		end else if (newWord) begin
			txAcc <= '0;
		end else if (txStrobe) begin
			txAcc <= txAccSum - refExt; // [R03]
		end else begin
			txAcc <= txAccSum;
		end
	end

	// serializer
	logic [9:0] txShift;
	logic [3:0] txIdx;
	logic       txBit;
	logic       txBitValid;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			txShift    <= TX_RESET_WORD;
			txIdx      <= 4'ha;
			txBit      <= 1'b0;
			txBitValid <= 1'b0;
		end else if (newWord) begin
			// launched straight from the crossing to keep latency low [R09]
			txShift    <= holdWord;
			txBit      <= holdWord[0]; // [R02]
			txIdx      <= 4'h1;
			txBitValid <= 1'b1;
		end else if (txStrobe && txIdx < 4'ha) begin
			txBit      <= txShift[txIdx]; // [R02]
			txIdx      <= txIdx + 4'h1;
			txBitValid <= 1'b1;
		end else begin
			txBitValid <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			serialOut <= '{p: 1'b1, n: 1'b0};
		end else if (lbk) begin
			serialOut <= '{p: 1'b1, n: 1'b0}; // [R06]
		end else begin
			serialOut <= '{p: txBit, n: ~txBit};
		end
	end

	// receive bit recovery: every input transition re-centres sampling so
	// the next strobe falls one system clock later, inside even a short bit
	logic             serPrev;
	logic             serEdge;
	logic [ACC_W-1:0] rxAcc;
	logic [ACC_W-1:0] rxAccSum;
	logic             rxStrobe;
	logic             rxBit;
	logic             rxBitValid;

	assign serEdge  = serIn ^ serPrev;
	assign rxAccSum = rxAcc + STEP;
	assign rxStrobe = !serEdge && refPeriod != PER_RESET &&
	                  rxAccSum >= refExt;
	assign rxBit      = lbk ? txBit : serIn; // [R05]
	assign rxBitValid = lbk ? txBitValid : (sigOk && rxStrobe);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			serPrev <= 1'b0;
			rxAcc   <= '0;
		end else begin
			serPrev <= serIn;
			if (serEdge) begin
				rxAcc <= refExt - STEP; // [R11]
			end else if (rxStrobe) begin
				rxAcc <= rxAccSum - refExt; // [R08]
			end else begin
				rxAcc <= rxAccSum;
			end
		end
	end

	// deserializer and comma alignment
	logic [9:0] rxShift;
	logic [9:0] nextShift;
	logic [3:0] rxCount;
	logic       isComma;
	logic       wordReady;
	logic [9:0] wordData;
	logic       wordComma;

	// new bits enter at the top, so the oldest bit ends in bit 0
	assign nextShift = {rxBit, rxShift[9:1]}; // [R15]
	assign isComma   = (nextShift & COMMA_MASK) == COMMA_VALUE;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxShift   <= RX_LOST_WORD;
			rxCount   <= 4'h0;
			wordReady <= 1'b0;
			wordData  <= RX_LOST_WORD;
			wordComma <= 1'b0;
		end else if (rxBitValid) begin
			rxShift <= nextShift;
			if (commaEn && isComma) begin
				rxCount   <= 4'h0; // [R13]
				wordReady <= 1'b1;
				wordData  <= nextShift;
				wordComma <= 1'b1;
			end else if (rxCount == 4'h9) begin
				rxCount   <= 4'h0;
				wordReady <= 1'b1;
				wordData  <= nextShift;
				wordComma <= 1'b0;
			end else begin
				rxCount   <= rxCount + 4'h1;
				wordReady <= 1'b0;
			end
		end else begin
			wordReady <= 1'b0;
		end
	end

	// output stage: data first, byte clock one system clock later so the
	// word is settled before its edge
	logic presentReady;
	logic presentComma;
	logic nextIsA;
	logic started;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxOut         <= '{word: RX_LOST_WORD, commaSeen: 1'b0};
			signalPresent <= 1'b0;
			presentReady  <= 1'b0;
			presentComma  <= 1'b0;
		end else begin
			signalPresent <= sigOk;
			presentReady  <= wordReady;
			presentComma  <= wordComma;
			if (!sigOk && !lbk) begin
				rxOut <= '{word: RX_LOST_WORD, commaSeen: 1'b0}; // [R07]
			end else if (wordReady) begin
				rxOut <= '{word: wordData, commaSeen: wordComma && commaEn};
			end else if (!commaEn) begin
				// a flag standing from before the disable is dropped at once
				rxOut.commaSeen <= 1'b0; // [R13]
			end
		end
	end

	// each clock is high for one word and low for the next, except that a comma word always goes to A: half word rate
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxByteClockA <= 1'b0;
			rxByteClockB <= 1'b0;
			nextIsA      <= 1'b1;
			started      <= 1'b0;
		end else if (presentReady) begin
			started <= 1'b1;
			// presentation delay sits here for the receive latency [R10]
			if (presentComma || nextIsA) begin
				rxByteClockA <= 1'b1; // [R14]
				rxByteClockB <= 1'b0;
				nextIsA      <= 1'b0;
			end else begin
				rxByteClockA <= 1'b0; // [R08]
				rxByteClockB <= 1'b1;
				nextIsA      <= 1'b1;
			end
		end
	end

	// helper logic for the checks below
	logic [LT_W-1:0] lockTimer;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lockTimer <= '0;
		end else if (lockTimer != LT_W'(LOCK_CYCLES_P)) begin
			lockTimer <= lockTimer + LT_W'(1);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_loop_line_one: assert property ( // [R06]
		lbk |=> serialOut.p && !serialOut.n)
		else $error("line output not held at one in loopback");
	a_tx_first_bit: assert property ( // [R02]
		newWord |=> txBit == $past(holdWord[0]) && txIdx == 4'h1)
		else $error("word did not start with bit 0");
	a_tx_latency: assert property ( // [R09]
		newWord ##1 !lbk |=> serialOut.p == $past(holdWord[0], 2))
		else $error("first serial bit not on the line in time");
	a_ten_bits_word: assert property ( // [R03]
		newWord && freqLocked && $past(freqLocked) |-> txIdx == 4'ha)
		else $error("not ten bits in a reference period");
	a_loop_rx_source: assert property ( // [R05]
		lbk && txBitValid |=> rxShift[9] == $past(txBit))
		else $error("loopback bit not taken into receive path");
	a_lost_all_ones: assert property ( // [R07]
		!sigOk && !lbk |=> rxOut.word == RX_LOST_WORD && !rxOut.commaSeen)
		else $error("lost signal did not force ones");
	a_lost_flag_low: assert property ( // [R07]
		!sigOk ##1 !sigOk |-> !signalPresent)
		else $error("signal present high with weak input");
	a_comma_off_low: assert property ( // [R13]
		!commaEn |=> !rxOut.commaSeen)
		else $error("comma seen with alignment disabled");
	a_comma_align_word: assert property ( // [R13]
		rxBitValid && commaEn && isComma |=>
		wordReady && wordComma && (wordData & COMMA_MASK) == COMMA_VALUE)
		else $error("comma did not start a word");
	a_comma_clock_a: assert property ( // [R14]
		wordReady && wordComma |=> ##1 rxByteClockA && !rxByteClockB)
		else $error("clock A did not rise on comma word");
	a_clocks_antiphase: assert property ( // [R14]
		started |-> rxByteClockA != rxByteClockB)
		else $error("byte clocks not in antiphase");
	a_last_bit_top: assert property ( // [R15]
		rxBitValid && rxCount == 4'h9 |=>
		wordReady && wordData[9] == $past(rxBit))
		else $error("last received bit not in bit 9");
	a_resync_edge: assert property ( // [R11]
		serEdge && !lbk && sigOk && refPeriod > PER_W'(20) |=>
		rxStrobe || serEdge)
		else $error("no sample point after input transition");
	a_lock_in_time: assert property ( // [R12]
		lockTimer == LT_W'(LOCK_CYCLES_P) |-> freqLocked)
		else $error("frequency lock not reached in time");
	c_loopback_word: cover property (lbk && wordReady);
	c_comma_aligned: cover property (wordReady && wordComma ##[1:40] wordReady);
	c_signal_lost: cover property (sigOk ##1 !sigOk);
	c_locked: cover property (!freqLocked ##1 freqLocked);
endmodule

// File: hw/sgp_pkg.sv
// constants, reset values and carrier types of the serdes pma datapath
// assumes a 200 MHz system clock and a 125 MHz transmit reference clock
package sgp_pkg;

	// word format
	localparam int WORD_W        = 10;
	localparam int BITS_PER_WORD = 10;
	localparam logic [9:0] COMMA_MASK  = 10'h07f;
	localparam logic [9:0] COMMA_VALUE = 10'h07c;
	localparam logic [9:0] RX_LOST_WORD = 10'h3ff;
	localparam logic [9:0] TX_RESET_WORD = 10'h000;

	// rates
	localparam int MCLK_MHZ        = 200;
	localparam int REF_MHZ         = 125;
	localparam int SERIAL_MHZ      = 1250;
	localparam int BYTE_CLOCK_KHZ  = 62500;
	localparam int REF_TOL_PPM     = 100;

	// typical latencies, in tenths of a bit and in picoseconds
	localparam int TX_LAT_TENTH_BITS = 44;
	localparam int TX_LAT_PS         = 3500;
	localparam int RX_LAT_TENTH_BITS = 280;
	localparam int RX_LAT_PS         = 22400;

	// acquisition bounds
	localparam int BIT_SYNC_BITS = 2500;
	localparam int LOCK_TIME_US  = 500;
	localparam int LOCK_CYCLES   = LOCK_TIME_US * MCLK_MHZ;

	// reference period counter width in system clocks
	localparam int PER_W = 12;
	localparam logic [PER_W-1:0] PER_RESET = 12'h000;

	typedef struct packed {
		logic [9:0] word;
		logic       commaSeen;
	} sgp_rx_s;

	typedef struct packed {
		logic p;
		logic n;
	} sgp_diff_s;

endpackage

// File: hw/sgp_sync2.sv
// two flip-flop level synchroniser, one per bit
// assumes inputs are levels that stay put for several destination clocks
`timescale 1ns/10ps
module sgp_sync2 #(
	parameter int W = 1
) (
	// clock and reset of the destination domain
	input  wire logic         clk,
	input  wire logic         reset,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule

// File: verification/sgp_host_model.sv
// parallel-side controller model: free-running reference clock and a
// repeating stream of already coded transmit words
// assumes the datapath captures txWord on the reference rising edge
`timescale 1ns/10ps
module sgp_host_model (
	// transmit reference and parallel word
	output logic       referenceClockIn,
	output logic [9:0] txWord
);
	// comma first, then words with no run of five ones, so no false comma
	logic [9:0] pattern [4] = '{10'h17c, 10'h2aa, 10'h155, 10'h2aa};
	logic [1:0] idx;

	// nominal 125 ns period, exactly 25 mclk; odd start offset keeps its edges off the mclk edges
	initial begin
		referenceClockIn = 1'b0;
		#3.3;
		forever #62.5 referenceClockIn = ~referenceClockIn;
	end

	initial begin
		idx    = 2'h0;
		txWord = 10'h17c;
	end

	// words change on the falling edge, well clear of the capture edge
	always @(negedge referenceClockIn) begin
		idx    <= idx + 2'h1;
		txWord <= pattern[idx + 2'h1];
	end
endmodule

// File: verification/tb.sv
// self-checking bench of the serdes datapath: reset, lock, loopback and
// external-wire streams, loss of signal, comma alignment off
// assumes the host model supplies the reference clock and words
`timescale 1ns/10ps
module tb;
	import sgp_pkg::*;
	localparam int LOCK_N = 2000;
	logic       mclk;
	logic       reset;
	logic       loopbackEnable;
	logic       commaAlignEnable;
	logic       serialIn;
	logic       lineAboveThreshold;
	logic       extWire;
	logic       referenceClockIn;
	logic [9:0] txWord;
	sgp_diff_s  serialOut;
	sgp_rx_s    rxOut;
	logic       rxByteClockA;
	logic       rxByteClockB;
	logic       signalPresent;
	logic       freqLocked;
	int         mismatches;
	int         n_checks;

	sgp_host_model sgp_host_model_inst (
		.referenceClockIn(referenceClockIn),
		.txWord          (txWord)
	);

	sgp_pma_datapath #(.LOCK_CYCLES_P(LOCK_N)) sgp_pma_datapath_inst (
		.mclk              (mclk),
		.reset             (reset),
		.referenceClockIn  (referenceClockIn),
		.txWord            (txWord),
		.loopbackEnable    (loopbackEnable),
		.commaAlignEnable  (commaAlignEnable),
		.serialIn          (serialIn),
		.lineAboveThreshold(lineAboveThreshold),
		.serialOut         (serialOut),
		.rxOut             (rxOut),
		.rxByteClockA      (rxByteClockA),
		.rxByteClockB      (rxByteClockB),
		.signalPresent     (signalPresent),
		.freqLocked        (freqLocked)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// external wire: the line output fed straight back to the line input
	always @(negedge mclk) begin
		serialIn <= extWire ? serialOut.p : 1'b0;
	end

	task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// bounded wait for a rising level on byte clock A or B
	task automatic wait_rise(input logic useA);
		logic prev;
		logic cur;
		int   i;
		prev = useA ? rxByteClockA : rxByteClockB;
		for (i = 0; i < 200; i++) begin
			@(negedge mclk);
			cur = useA ? rxByteClockA : rxByteClockB;
			if (cur === 1'b1 && prev === 1'b0)
				break;
			prev = cur;
		end
		check_flag(i < 200, 1'b1);
	endtask

	task automatic t_reset();
		check_word({8'h00, serialOut}, 10'h002);
		check_word(rxOut.word, RX_LOST_WORD);
		check_flag(rxOut.commaSeen, 1'b0);
		check_flag(signalPresent, 1'b0);
		check_flag(freqLocked, 1'b0);
	endtask

	task automatic t_lock();
		int i;
		for (i = 0; i < LOCK_N + 200; i++) begin
			@(negedge mclk);
			if (freqLocked === 1'b1)
				break;
		end
		check_flag(freqLocked, 1'b1);
	endtask

	// comma on A, then words alternate B, A, B in transmit order
	task automatic t_stream(input logic loop);
		int i;
		loopbackEnable   = loop;
		extWire          = ~loop;
		commaAlignEnable = 1'b1;
		for (i = 0; i < 40; i++) begin
			wait_rise(1'b1);
			if (rxOut.commaSeen === 1'b1)
				break;
		end
		check_word(rxOut.word, 10'h17c);
		check_flag(rxOut.commaSeen, 1'b1);
		if (loop)
			check_word({8'h00, serialOut}, 10'h002);
		else
			check_flag(serialOut.n, ~serialOut.p);
		wait_rise(1'b0);
		check_word(rxOut.word, 10'h2aa);
		check_flag(rxOut.commaSeen, 1'b0);
		wait_rise(1'b1);
		check_word(rxOut.word, 10'h155);
		wait_rise(1'b0);
		check_word(rxOut.word, 10'h2aa);
		if (loop)
			check_word({8'h00, serialOut}, 10'h002);
	endtask

	// weak line: receive word held at all ones until the line returns
	task automatic t_lost();
		int i;
		lineAboveThreshold = 1'b0;
		repeat (10) @(negedge mclk);
		check_flag(signalPresent, 1'b0);
		for (i = 0; i < 30; i++) begin
			@(negedge mclk);
			check_word(rxOut.word, RX_LOST_WORD);
		end
		check_flag(rxOut.commaSeen, 1'b0);
		lineAboveThreshold = 1'b1;
		repeat (10) @(negedge mclk);
		check_flag(signalPresent, 1'b1);
	endtask

	// alignment off: comma words keep flowing but never get flagged
	task automatic t_nocomma();
		logic seen;
		int   i;
		loopbackEnable   = 1'b1;
		extWire          = 1'b0;
		commaAlignEnable = 1'b0;
		repeat (10) @(negedge mclk);
		seen = 1'b0;
		for (i = 0; i < 400; i++) begin
			@(negedge mclk);
			seen = seen | (rxOut.commaSeen !== 1'b0);
		end
		check_flag(seen, 1'b0);
	endtask

	task automatic results();
		$display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		reset              = 1'b1;
		loopbackEnable     = 1'b0;
		commaAlignEnable   = 1'b1;
		lineAboveThreshold = 1'b1;
		extWire            = 1'b0;
		serialIn           = 1'b0;
		mismatches         = 0;
		n_checks           = 0;
		// the reference domain leaves reset on its own edges after release
		repeat (20) @(negedge mclk);
		t_reset();
		reset = 1'b0;
		t_lock();
		t_stream(1'b1);
		t_stream(1'b0);
		t_lost();
		t_nocomma();
		results();
	end

	// whole run needs roughly 1100 mclk; this leaves ample margin
	initial begin
		#150000;
		mismatches++;
		results();
	end
endmodule
